// ===== pab_consts.svh
// Constants for the general-purpose port with buzzer pair
// Functional notes
// - Data latch is one byte at 12H; seven two-way lines, one input-only line.
// - Port reads are not latched; pads sampled at the second clock phase edge.
// - Written outputs stay in the latch until software writes it again.
// - Direction bit 1 means input, 0 means output; input-only line stays input.
// - Direction register sits at 13H and may change at any time.
// - Read returns pad for input lines, latch for output lines.
// - Bit set, clear, complement read the port, modify, write back; complement here inverts all eight bits, not the selected bit.
// - After reset all lines are inputs with latches set.
// - Outputs are push-pull only; inputs Schmitt or CMOS with optional pull-high.
// - Wake-up enable at 15H, bits 0 to 6; bit 7 reads zero.
// - Pull-high enable at 14H, bits 0 to 6; bit 7 reads zero.
// - Input-only line has no wake-up and no pull-high.
// - Buzzer option: lines 0 and 1 as outputs drive buzzer and its complement.
// - Both buzzer outputs gated only by line 0 data bit.
// - Buzzer line drives 0 when gate bit is 0, else buzzer signal.
// - One option selects CMOS or Schmitt input stage for all lines.
`ifndef PAB_CONSTS_SVH
`define PAB_CONSTS_SVH
`define PAB_ADDR_DATA 8'h12
`define PAB_ADDR_DIR 8'h13
`define PAB_ADDR_PULL 8'h14
`define PAB_ADDR_WAKE 8'h15
`define PAB_DATA_RST 8'hFF
`define PAB_DIR_RST 8'hFF
`define PAB_MASK_RST 8'h00
`define PAB_MASK_BITS 8'h7F
`define PAB_INPUT_ONLY_BIT 7
`define PAB_GATE_BIT 0
`define PAB_COMP_BIT 1
`endif

// ===== pab_pkg.sv
// Types for the general-purpose port with buzzer pair
`default_nettype none
package pab_pkg;
  typedef enum logic [1:0] {
    PAB_OP_NONE,
    PAB_OP_SET,
    PAB_OP_CLR,
    PAB_OP_CPL
  } pab_bitop_t;
endpackage : pab_pkg
`default_nettype wire

// ===== pab_sync.sv
// Two-stage synchroniser for the port pads
`default_nettype none
module pab_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pab_sync
`default_nettype wire

// ===== pab_pad_mux.sv
// Pad drive selection with buzzer pair override
`default_nettype none
`include "pab_consts.svh"
module pab_pad_mux #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] dir,
  input wire logic buzzer_enable,
  input wire logic buzzer_signal,
  output logic [WIDTH-1:0] drive,
  output logic [WIDTH-1:0] drive_en
);
  logic gate;

  // Gate is the line 0 data bit only
  assign gate = latch[`PAB_GATE_BIT];

  always_comb begin
    drive = latch;
    drive_en = ~dir;
    drive_en[`PAB_INPUT_ONLY_BIT] = 1'b0;
    if (buzzer_enable) begin
      drive[`PAB_GATE_BIT] = gate & buzzer_signal;
      drive[`PAB_COMP_BIT] = gate & ~buzzer_signal;
    end
  end
endmodule : pab_pad_mux
`default_nettype wire

// ===== pab_port.sv
// Eight-line port with direction, pull-high, wake-up and buzzer pair
`default_nettype none
`include "pab_consts.svh"
module pab_port
  import pab_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  input wire logic [2:0] bit_sel,
  input wire pab_bitop_t bit_op,
  input wire logic second_clock_phase,
  output logic [7:0] mem_rdata,
  input wire logic [WIDTH-1:0] port_lines_in,
  output logic [WIDTH-1:0] port_lines_out,
  output logic [WIDTH-1:0] port_lines_oe,
  output logic [WIDTH-1:0] pullhigh_on,
  input wire logic buzzer_option,
  input wire logic buzzer_out,
  input wire logic schmitt_select,
  output logic schmitt_on,
  input wire logic powered_down,
  output logic wakeup_req
);
  // ****************************************
  // Registers and pad synchroniser
  // ****************************************
  logic [WIDTH-1:0] port_data_latch_q;
  logic [WIDTH-1:0] port_direction_q;
  logic [WIDTH-1:0] pullhigh_enable_q;
  logic [WIDTH-1:0] wakeup_enable_q;
  logic [WIDTH-1:0] pad_sync;
  logic [WIDTH-1:0] pad_prev_q;
  logic [2:0] sync_fill_q;
  logic [WIDTH-1:0] drive;
  logic [WIDTH-1:0] drive_en;
  logic [WIDTH-1:0] port_view;
  logic [WIDTH-1:0] rmw_d;
  logic hit_data;
  logic data_wr;
  logic [WIDTH-1:0] data_wval;

  pab_sync #(.WIDTH(WIDTH)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(port_lines_in),
    .sync_out(pad_sync)
  );

  pab_pad_mux #(.WIDTH(WIDTH)) u_mux (
    .latch(port_data_latch_q),
    .dir(port_direction_q),
    .buzzer_enable(buzzer_option),
    .buzzer_signal(buzzer_out),
    .drive(drive),
    .drive_en(drive_en)
  );

  // ****************************************
  // Port view and bit operations
  // ****************************************
  function automatic logic [WIDTH-1:0] read_view(
    input logic [WIDTH-1:0] dir,
    input logic [WIDTH-1:0] pad,
    input logic [WIDTH-1:0] latch
  );
    logic [WIDTH-1:0] d;
    d = dir;
    d[`PAB_INPUT_ONLY_BIT] = 1'b1;
    return (d & pad) | (~d & latch);
  endfunction : read_view

  function automatic logic [WIDTH-1:0] apply_op(
    input logic [WIDTH-1:0] val,
    input pab_bitop_t op,
    input logic [2:0] sel
  );
    logic [WIDTH-1:0] m;
    m = '0;
    m[sel] = 1'b1;
    case (op)
      PAB_OP_SET: apply_op = val | m;
      PAB_OP_CLR: apply_op = val & ~m;
      PAB_OP_CPL: apply_op = ~val;
      default: apply_op = val;
    endcase
  endfunction : apply_op

  assign port_view = read_view(port_direction_q, pad_sync,
                               port_data_latch_q);
  assign rmw_d = apply_op(port_view, bit_op, bit_sel);
  assign hit_data = (mem_addr == `PAB_ADDR_DATA);
  assign data_wr = hit_data && (mem_wr || bit_op != PAB_OP_NONE);
  assign data_wval = (bit_op != PAB_OP_NONE) ? rmw_d : mem_wdata;

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_data_latch_q <= `PAB_DATA_RST;
    end else if (data_wr) begin
      port_data_latch_q <= data_wval;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_direction_q <= `PAB_DIR_RST;
    end else if (mem_wr && mem_addr == `PAB_ADDR_DIR) begin
      port_direction_q <= mem_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pullhigh_enable_q <= `PAB_MASK_RST;
    end else if (mem_wr && mem_addr == `PAB_ADDR_PULL) begin
      pullhigh_enable_q <= mem_wdata & `PAB_MASK_BITS;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wakeup_enable_q <= `PAB_MASK_RST;
    end else if (mem_wr && mem_addr == `PAB_ADDR_WAKE) begin
      wakeup_enable_q <= mem_wdata & `PAB_MASK_BITS;
    end
  end

  // ****************************************
  // Read data, sampled on the second phase edge
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd && second_clock_phase) begin
      case (mem_addr)
        `PAB_ADDR_DATA: mem_rdata <= port_view;
        `PAB_ADDR_DIR: mem_rdata <= port_direction_q;
        `PAB_ADDR_PULL: mem_rdata <= pullhigh_enable_q;
        `PAB_ADDR_WAKE: mem_rdata <= wakeup_enable_q;
        default: mem_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Pad outputs and wake-up
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_lines_out <= '0;
      port_lines_oe <= '0;
      pullhigh_on <= '0;
      schmitt_on <= 1'b0;
    end else begin
      port_lines_out <= drive;
      port_lines_oe <= drive_en;
      pullhigh_on <= pullhigh_enable_q & port_direction_q;
      schmitt_on <= schmitt_select;
    end
  end

  // Marks when both pad stages and the previous copy hold real samples
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_fill_q <= 3'h0;
    end else begin
      sync_fill_q <= {sync_fill_q[1:0], 1'h1};
    end
  end

  // Reset zeros in the pad stages would look like an edge on idle-high pins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pad_prev_q <= '0;
      wakeup_req <= 1'b0;
    end else begin
      pad_prev_q <= pad_sync;
      wakeup_req <= powered_down && sync_fill_q[2] &&
        |((pad_sync ^ pad_prev_q) & wakeup_enable_q
          & port_direction_q);
    end
  end
endmodule : pab_port
`default_nettype wire

// ===== pab_port_properties.sv
// Checker for the port block, bound to its top module
`default_nettype none
module pab_port_chk
  import pab_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire pab_bitop_t bit_op,
  input wire logic second_clock_phase,
  input wire logic [7:0] mem_rdata,
  input wire logic [WIDTH-1:0] port_lines_out,
  input wire logic [WIDTH-1:0] port_lines_oe,
  input wire logic [WIDTH-1:0] pullhigh_on,
  input wire logic buzzer_option,
  input wire logic schmitt_select,
  input wire logic schmitt_on,
  input wire logic powered_down,
  input wire logic wakeup_req
);
  // ****
  // Port relations
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_OE7: assert property (!port_lines_oe[7])
    else $error("input-only line driven");
  AST_PULL7: assert property (!pullhigh_on[7])
    else $error("input-only line pulled");
  AST_PULLDIR: assert property ((pullhigh_on & port_lines_oe) == '0)
    else $error("pull on a driven line");
  AST_UNMAP: assert property (mem_rd && second_clock_phase &&
    !(mem_addr inside {[8'h12:8'h15]}) |=> mem_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDHOLD: assert property (!(mem_rd && second_clock_phase)
    |=> $stable(mem_rdata)) else $error("read data moved");
  AST_MASK7: assert property (mem_rd && second_clock_phase &&
    mem_addr inside {8'h14, 8'h15} |=> !mem_rdata[7])
    else $error("mask bit 7 not zero");
  AST_HOLD: assert property ((!mem_wr && bit_op == PAB_OP_NONE &&
    !buzzer_option)[*4] |-> $stable({port_lines_out, port_lines_oe}))
    else $error("pins changed without a write");
  AST_SCHMITT: assert property ($stable(schmitt_select)[*3]
    |-> schmitt_on == schmitt_select) else $error("input stage wrong");
  AST_WAKE: assert property (!powered_down[*2] |-> !wakeup_req)
    else $error("wake-up while running");
  AST_BZPAIR: assert property (buzzer_option[*2]
    |-> !(port_lines_out[0] && port_lines_out[1]))
    else $error("buzzer pair not complementary");
endmodule : pab_port_chk
bind pab_port pab_port_chk #(.WIDTH(WIDTH)) i_pab_port_chk (.core_clk,
  .reset, .mem_addr, .mem_wr, .mem_rd, .bit_op, .second_clock_phase,
  .mem_rdata, .port_lines_out, .port_lines_oe, .pullhigh_on,
  .buzzer_option, .schmitt_select, .schmitt_on, .powered_down,
  .wakeup_req);
`default_nettype wire

// ===== pab_pins.sv
// Board model of the port pads
`default_nettype none
module pab_pins (
  input wire logic [7:0] drive,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  input wire logic [7:0] ext,
  output logic [7:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad[i] = oe[i] ? drive[i] : (pull[i] ? 1'b1 : ext[i]);
    end
  end
endmodule : pab_pins
`default_nettype wire

// ===== test_pab_port.sv
// Self-checking bench for the port block
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
  failures++; $display("Error %s exp %h got %h", n, e, s); end end
module test_pab_port
  import pab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, mem_wr = 0, mem_rd = 0, ph = 0, wk;
  logic bz_opt = 0, bz = 0, sch = 0, sch_on, pd = 0, rd_now = 0;
  logic [7:0] mem_addr = 0, mem_wdata = 0, ext = 0, mem_rdata, out, oe;
  logic [7:0] pull, pad, lat, dir, pu, e_v;
  logic [2:0] bit_sel = 0;
  pab_bitop_t bit_op = PAB_OP_NONE;
  int failures = 0, check_count = 0, cyc = 0;
  logic [7:0] exp_q[$];
  pab_port #(.WIDTH(8)) i_pab_port (.core_clk, .reset, .mem_addr, .mem_wr,
    .mem_wdata, .mem_rd, .bit_sel, .bit_op, .second_clock_phase(ph),
    .mem_rdata, .port_lines_in(pad), .port_lines_out(out),
    .port_lines_oe(oe), .pullhigh_on(pull), .buzzer_option(bz_opt),
    .buzzer_out(bz), .schmitt_select(sch), .schmitt_on(sch_on),
    .powered_down(pd), .wakeup_req(wk));
  pab_pins i_pab_pins (.drive(out), .oe, .pull, .ext, .pad);
  // ****
  // Clock, watchdog, monitor
  // ****
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      stop_test();
    end
  end
  always @(posedge core_clk) rd_now <= mem_rd & ph;
  always @(negedge core_clk) begin
    if (rd_now) begin
      e_v = exp_q.pop_front();
      `CHK("mem_rdata", e_v, mem_rdata)
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick
  task automatic wr(logic [7:0] a, logic [7:0] d);
    tick(1);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1;
    tick(1);
    mem_wr = 0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    tick(1);
    mem_addr = a;
    mem_rd = 1;
    ph = 1;
    exp_q.push_back(e);
    tick(1);
    mem_rd = 0;
    ph = 0;
  endtask : rd
  task automatic rmw(pab_bitop_t o, logic [2:0] s);
    tick(1);
    mem_addr = 8'h12;
    bit_op = o;
    bit_sel = s;
    tick(1);
    bit_op = PAB_OP_NONE;
  endtask : rmw
  function automatic logic [7:0] view();
    logic [7:0] d = dir | 8'h80;
    return (lat & ~d) | (((pu & 8'h7F) | ext) & d);
  endfunction : view
  task automatic stop_test();
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    logic [2:0] s;
    logic [7:0] ox;
    int n;
    void'($urandom(11));
    ext = $urandom;
    lat = 8'hFF;
    dir = 8'hFF;
    pu = 0;
    repeat (5) @(posedge core_clk);
    #2 reset = 0;
    tick(4);
    rd(8'h12, view());
    rd(8'h13, 8'hFF);
    rd(8'h14, 8'h00);
    rd(8'h16, 8'h00);
    wr(8'h14, 8'hFF);
    pu = 8'h7F;
    wr(8'h15, 8'hFF);
    rd(8'h14, 8'h7F);
    rd(8'h15, 8'h7F);
    for (int k = 0; k < 4; k++) begin
      lat = $urandom;
      dir = $urandom;
      ext = $urandom;
      ox = {1'b0, ~dir[6:0]};
      wr(8'h12, lat);
      wr(8'h13, dir);
      tick(4);
      rd(8'h12, view());
      `CHK("port_lines_oe", ox, oe)
      `CHK("port_lines_out", lat & ox, out & ox)
      `CHK("pullhigh_on", dir & 8'h7F, pull)
    end
    wr(8'h13, 8'h00);
    dir = 0;
    for (int k = 1; k < 4; k++) begin
      s = $urandom;
      rmw(pab_bitop_t'(k), s);
      lat = k == 1 ? lat | (8'h01 << s) : k == 2 ? lat & ~(8'h01 << s)
        : ~view();
      rd(8'h12, view());
    end
    bz_opt = 1;
    for (int k = 0; k < 4; k++) begin
      bz = k[0];
      wr(8'h12, {6'h00, k[0], k[1]});
      tick(3);
      `CHK("buzzer", k[1] ? {~bz, bz} : 2'b00, out[1:0])
    end
    bz_opt = 0;
    for (int k = 1; k >= 0; k--) begin
      sch = k[0];
      tick(3);
      `CHK("schmitt_on", sch, sch_on)
    end
    wr(8'h13, 8'hFF);
    wr(8'h14, 8'h00);
    tick(4);
    pd = 1;
    tick(2);
    ext[2] = ~ext[2];
    n = 0;
    while (wk !== 1'b1 && n < 6) begin
      tick(1);
      n++;
    end
    `CHK("wakeup_req", 1'b1, wk)
    stop_test();
  end
endmodule : test_pab_port
`default_nettype wire
